// [src/pwm_timer_top.sv]
// PWM channel block of a 16-bit timer: APB registers, counter, pairs.
// Assumes an APB master on the system clock and loads on the channel pins.
//
// Behaviour
// - Output compare edge 0:0: flag, pin released
// - Edge PWM chosen by mode select b
// - Edge PWM flag at channel value match
// - Edge PWM 1:0 high at reload, low at match
// - Edge PWM zero 0%, above final 100%
// - Center select gives up-down counting
// - Center PWM flag on both matches
// - Center PWM edge 0:0: flag, pin released
// - Center PWM high down match, low up
// - Center PWM zero or negative gives 0%
// - Center PWM value at final gives 100%
// - Combine needs enhanced, combine, no center
// - Combine period from counter, edges independent
// - Combine flags on each channel match
// - Combine low at start, odd match; high even
// - Combine pins released by own edge 0:0
// - Complement bit inverts odd output, in combine only
//
// The APB slave port and the register offsets were left to the implementer.
`include "pwm_defs.svh"
module pwm_timer_top import pwm_pkg::*; #(
    parameter int NUM_PAIRS = 2
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Channel pins
    output logic [2*NUM_PAIRS-1:0] o_ch_out,
    output logic [2*NUM_PAIRS-1:0] o_ch_oe,
    // Channel interrupt requests
    output logic [2*NUM_PAIRS-1:0] o_ch_irq
);
    localparam int NCH = 2 * NUM_PAIRS;

    // ==========================================================
    // Register state
    logic [3:0] ctrl_q;
    logic [15:0] start_q, final_q;
    logic [NCH-1:0] pair_q, flag_q;
    logic [4:0] chctl_q [NCH];
    logic [15:0] chval_q [NCH];
    logic [31:0] prdata_q;

    // Counter and channel wiring
    logic [15:0] count;
    logic down, run, center, enhanced, dual_cap, free_run;
    logic [NCH-1:0] flag_set;
    chan_mode_e mode [NCH];

    // ==========================================================
    // Address decode
    logic wr_en, rd_setup, hit, is_chctl, is_chval;
    logic [7:0] ch_idx;
    logic [31:0] rd_word;
    logic [NCH-1:0] flag_clr;

    // Index within a per-channel window
    function automatic logic [7:0] ch_index(input logic [7:0] addr,
            input logic [7:0] base);
        logic [7:0] diff;
        diff = addr - base;
        return {2'b00, diff[7:2]};
    endfunction : ch_index

    // Address inside a per-channel window
    function automatic logic in_window(input logic [7:0] addr, input logic [7:0] base);
        return (addr >= base) && (addr < 8'(base + 8'(4 * NCH))) && (addr[1:0] == 2'b00);
    endfunction : in_window

    assign is_chctl = in_window(i_paddr, `PWM_CHCTL_BASE);
    assign is_chval = in_window(i_paddr, `PWM_CHVAL_BASE);
    assign ch_idx = is_chctl ? ch_index(i_paddr, `PWM_CHCTL_BASE)
                  : ch_index(i_paddr, `PWM_CHVAL_BASE);
    assign hit = is_chctl || is_chval || i_paddr == `PWM_CTRL_OFF
        || i_paddr == `PWM_START_OFF || i_paddr == `PWM_FINAL_OFF
        || i_paddr == `PWM_COUNT_OFF || i_paddr == `PWM_PAIR_OFF
        || i_paddr == `PWM_FLAG_OFF;

    // Zero wait states; unmapped addresses answer with an error
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !hit;
    assign wr_en = i_psel && i_penable && i_pwrite && hit;
    assign rd_setup = i_psel && !i_penable && !i_pwrite;
    assign o_prdata = prdata_q;

    // Read multiplexer
    always_comb begin
        rd_word = 32'h0000_0000;
        if (is_chctl) begin
            rd_word = {27'h0000000, chctl_q[ch_idx[1:0]]};
        end else if (is_chval) begin
            rd_word = {16'h0000, chval_q[ch_idx[1:0]]};
        end else begin
            case (i_paddr)
                `PWM_CTRL_OFF: rd_word = {28'h0000000, ctrl_q};
                `PWM_START_OFF: rd_word = {16'h0000, start_q};
                `PWM_FINAL_OFF: rd_word = {16'h0000, final_q};
                `PWM_COUNT_OFF: rd_word = {16'h0000, count};
                `PWM_PAIR_OFF: rd_word = 32'(pair_q);
                `PWM_FLAG_OFF: rd_word = 32'(flag_q);
                default: rd_word = 32'h0000_0000;
            endcase
        end
    end

    // Read data captured in the setup cycle, valid through the access
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_q <= rd_word;
        end
    end

    // ==========================================================
    // Global control and counter values
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_q <= `CTRL_RESET;
            start_q <= `WORD16_RESET;
            final_q <= `WORD16_RESET;
            pair_q <= '0;
        end else if (wr_en) begin
            case (i_paddr)
                `PWM_CTRL_OFF: ctrl_q <= i_pwdata[3:0];
                `PWM_START_OFF: start_q <= i_pwdata[15:0];
                `PWM_FINAL_OFF: final_q <= i_pwdata[15:0];
                `PWM_PAIR_OFF: pair_q <= i_pwdata[2*NUM_PAIRS-1:0];
                default: ;
            endcase
        end
    end

    // Per-channel control and value
    // Write buffering is not modelled: a new value applies from the next tick
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int i = 0; i < NCH; i++) begin
                chctl_q[i] <= 5'h00;
                chval_q[i] <= `WORD16_RESET;
            end
        end else if (wr_en && is_chctl) begin
            chctl_q[ch_idx[1:0]] <= i_pwdata[4:0];
        end else if (wr_en && is_chval) begin
            chval_q[ch_idx[1:0]] <= i_pwdata[15:0];
        end
    end

    // ==========================================================
    // Sticky flags: write one to clear, a new event wins over the clear
    assign flag_clr = (wr_en && i_paddr == `PWM_FLAG_OFF) ? i_pwdata[NCH-1:0] : '0;

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            flag_q <= '0;
        end else begin
            flag_q <= (flag_q & ~flag_clr) | flag_set;
        end
    end

    // Interrupt request: flag gated by its enable
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            o_ch_irq[i] = flag_q[i] && chctl_q[i][`CHCTL_IE_BIT];
        end
    end

    // ==========================================================
    // Shared counter
    assign run = ctrl_q[`CTRL_RUN_BIT];
    assign center = ctrl_q[`CTRL_CENTER_BIT];
    assign enhanced = ctrl_q[`CTRL_ENH_BIT];
    assign dual_cap = ctrl_q[`CTRL_DUALCAP_BIT];
    // Full-range wrap when no usable final value
    assign free_run = (!enhanced && (final_q == 16'h0000 || final_q == `COUNT_TOP))
        || (enhanced && !center && start_q == 16'h0000 && final_q == `COUNT_TOP);

    pwm_counter u_counter (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_run(run),
        .i_center(center),
        .i_free(free_run),
        .i_start(start_q),
        .i_final(final_q),
        .o_count(count),
        .o_down(down)
    );

    // ==========================================================
    // Channel modes and pairs
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            mode[i] = mode_of(dual_cap, center, enhanced, pair_q[2*(i/2)],
                chctl_q[i][`CHCTL_MSB_BIT], chctl_q[i][`CHCTL_MSA_BIT]);
        end
    end

    for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
        pwm_pair u_pair (
            .i_sys_clk(i_sys_clk),
            .i_rst_b(i_rst_b),
            .i_tick(run),
            .i_count(count),
            .i_down(down),
            .i_start(start_q),
            .i_final(final_q),
            .i_mode_e(mode[2*p]),
            .i_mode_o(mode[2*p+1]),
            .i_els_e(chctl_q[2*p][`CHCTL_ELS_LO+1:`CHCTL_ELS_LO]),
            .i_els_o(chctl_q[2*p+1][`CHCTL_ELS_LO+1:`CHCTL_ELS_LO]),
            .i_val_e(chval_q[2*p]),
            .i_val_o(chval_q[2*p+1]),
            .i_comp(pair_q[2*p+1]),
            .o_out(o_ch_out[2*p+1:2*p]),
            .o_oe(o_ch_oe[2*p+1:2*p]),
            .o_flag_set(flag_set[2*p+1:2*p])
        );
    end
endmodule : pwm_timer_top

// [src/pwm_defs.svh]
// Offsets, field positions and reset values of the PWM block.
// Assumes 8-bit byte addresses and 32-bit data.
`ifndef PWM_DEFS_SVH
`define PWM_DEFS_SVH
// ==========================================================
// Register byte offsets
`define PWM_CTRL_OFF 8'h00
`define PWM_START_OFF 8'h04
`define PWM_FINAL_OFF 8'h08
`define PWM_COUNT_OFF 8'h0c
`define PWM_PAIR_OFF 8'h10
`define PWM_FLAG_OFF 8'h14
`define PWM_CHCTL_BASE 8'h20
`define PWM_CHVAL_BASE 8'h40
// ==========================================================
// Field positions
`define CTRL_RUN_BIT 0
`define CTRL_CENTER_BIT 1
`define CTRL_ENH_BIT 2
`define CTRL_DUALCAP_BIT 3
`define CHCTL_MSA_BIT 0
`define CHCTL_MSB_BIT 1
`define CHCTL_ELS_LO 2
`define CHCTL_IE_BIT 4
// ==========================================================
// Reset values and fixed counts
`define CTRL_RESET 4'h0
`define WORD16_RESET 16'h0000
`define COUNT_TOP 16'hffff
`endif

// [src/pwm_pkg.sv]
// Types shared by the PWM channel block.
// Assumes no other file.
package pwm_pkg;
    // ==========================================================
    // Channel operating modes
    typedef enum logic [2:0] {
        MODE_IDLE, MODE_OC, MODE_EDGE_ALIGNED_PWM, MODE_CENTER_ALIGNED_PWM, MODE_COMBINE
    } chan_mode_e;

    // Mode of one channel from its control bits
    function automatic chan_mode_e mode_of(input logic dual_capture_enable,
            input logic center_align_select, input logic enhanced_feature_enable,
            input logic pair_combine, input logic mode_select_b,
            input logic mode_select_a);
        chan_mode_e m;
        m = MODE_IDLE;
        if (dual_capture_enable) begin
            m = MODE_IDLE;
        end else if (pair_combine) begin
            if (enhanced_feature_enable && !center_align_select) begin
                m = MODE_COMBINE;
            end
        end else if (center_align_select) begin
            m = MODE_CENTER_ALIGNED_PWM;
        end else if (mode_select_b) begin
            m = MODE_EDGE_ALIGNED_PWM;
        end else if (mode_select_a) begin
            m = MODE_OC;
        end
        return m;
    endfunction : mode_of
endpackage : pwm_pkg

// [src/pwm_counter.sv]
// Shared 16-bit counter: up counting or up-down counting.
// Assumes start and final values are kept legal by software.
`include "pwm_defs.svh"
module pwm_counter import pwm_pkg::*; (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // Control
    input wire logic i_run,
    input wire logic i_center,
    input wire logic i_free,
    input wire logic [15:0] i_start,
    input wire logic [15:0] i_final,
    // Counter state
    output logic [15:0] o_count,
    output logic o_down
);
    logic [15:0] count_q, limit;
    logic down_q;

    // Free running mode wraps at the full range
    assign limit = i_free ? `COUNT_TOP : i_final;
    assign o_count = count_q;
    assign o_down = down_q;

    // ==========================================================
    // Counting
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            count_q <= `WORD16_RESET;
            down_q <= 1'b0;
        end else if (!i_run) begin
            count_q <= i_start;
            down_q <= 1'b0;
        end else if (i_center) begin
            // Turn at the final value, then back at the start value
            if (!down_q && count_q >= limit) begin
                down_q <= 1'b1;
                count_q <= count_q - 16'h0001;
            end else if (down_q && count_q <= i_start) begin
                down_q <= 1'b0;
                count_q <= count_q + 16'h0001;
            end else begin
                count_q <= down_q ? count_q - 16'h0001 : count_q + 16'h0001;
            end
        end else begin
            down_q <= 1'b0;
            count_q <= (count_q == limit) ? i_start : count_q + 16'h0001;
        end
    end
endmodule : pwm_counter

// [src/pwm_pair.sv]
// Waveform logic of one even/odd channel pair.
// Assumes count and direction come from the shared counter, tick from the run bit.
module pwm_pair import pwm_pkg::*; (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // Counter
    input wire logic i_tick,
    input wire logic [15:0] i_count,
    input wire logic i_down,
    input wire logic [15:0] i_start,
    input wire logic [15:0] i_final,
    // Channel set-up, index 0 even, 1 odd
    input wire chan_mode_e i_mode_e,
    input wire chan_mode_e i_mode_o,
    input wire logic [1:0] i_els_e,
    input wire logic [1:0] i_els_o,
    input wire logic [15:0] i_val_e,
    input wire logic [15:0] i_val_o,
    input wire logic i_comp,
    // Pins and flag events
    output logic [1:0] o_out,
    output logic [1:0] o_oe,
    output logic [1:0] o_flag_set
);
    logic [1:0] lvl_q, flag_q, step_e, step_o, lvl_d, flag_d;
    logic comb_lvl, comb_on;

    // {flag, next level} of one channel for one tick
    function automatic logic [1:0] chan_step(input chan_mode_e mode,
            input logic [1:0] els, input logic [15:0] val, input logic lvl,
            input logic [15:0] cnt, input logic down, input logic [15:0] start,
            input logic [15:0] fin);
        logic match, f, l;
        match = (cnt == val);
        f = 1'b0;
        l = lvl;
        case (mode)
            MODE_OC: begin
                f = match;
                if (match) begin
                    case (els)
                        2'b01: l = ~lvl;
                        2'b10: l = 1'b0;
                        2'b11: l = 1'b1;
                        default: l = lvl;
                    endcase
                end
            end
            MODE_EDGE_ALIGNED_PWM: begin
                // Polarity: X:1 swaps the levels of 1:0
                if (val == 16'h0000) begin
                    l = els[0];
                end else if (val > fin) begin
                    l = ~els[0];
                end else if (match) begin
                    f = 1'b1;
                    l = els[0];
                end else if (cnt == start) begin
                    l = ~els[0];
                end
            end
            MODE_CENTER_ALIGNED_PWM: begin
                if (val == 16'h0000 || val[15]) begin
                    l = els[0];
                end else if (val >= fin && fin != 16'h0000) begin
                    l = ~els[0];
                end else if (match) begin
                    f = 1'b1;
                    l = down ? ~els[0] : els[0];
                end
            end
            default: l = lvl;
        endcase
        return {f, l};
    endfunction : chan_step

    // ==========================================================
    // Next levels and flags
    assign comb_on = (i_mode_e == MODE_COMBINE);
    assign step_e = chan_step(i_mode_e, i_els_e, i_val_e, lvl_q[0], i_count, i_down,
        i_start, i_final);
    assign step_o = chan_step(i_mode_o, i_els_o, i_val_o, lvl_q[1], i_count, i_down,
        i_start, i_final);

    // Combine: odd match outranks even match so equal values give no pulse
    always_comb begin
        comb_lvl = lvl_q[0];
        if (i_count == i_val_o) begin
            comb_lvl = i_els_e[0];
        end else if (i_count == i_val_e) begin
            comb_lvl = ~i_els_e[0];
        end else if (i_count == i_start) begin
            comb_lvl = i_els_e[0];
        end
    end

    // Pick pair or single behaviour
    always_comb begin
        if (comb_on) begin
            flag_d = {i_count == i_val_o, i_count == i_val_e};
            lvl_d = {comb_lvl ^ i_comp, comb_lvl};
        end else begin
            flag_d = {step_o[1], step_e[1]};
            lvl_d = {step_o[0], step_e[0]};
        end
    end

    // ==========================================================
    // Registered once per tick
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            lvl_q <= 2'b00;
            flag_q <= 2'b00;
        end else begin
            lvl_q <= i_tick ? lvl_d : lvl_q;
            flag_q <= i_tick ? flag_d : 2'b00;
        end
    end

    // Edge select 0:0 on a channel releases its own pin
    assign o_out = lvl_q;
    assign o_oe = {|i_els_o, |i_els_e};
    assign o_flag_set = flag_q;
endmodule : pwm_pair

// [testbench/pwm_timer_chk.sv]
// Checker bound to the PWM block's top-level ports.
// Assumes register state follows from APB writes alone.
`include "pwm_defs.svh"
module pwm_timer_chk import pwm_pkg::*; #(
    parameter int NUM_PAIRS = 2
) (
    // Clock, reset and APB
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // Channel pins and requests
    input wire logic [2*NUM_PAIRS-1:0] o_ch_out,
    input wire logic [2*NUM_PAIRS-1:0] o_ch_oe,
    input wire logic [2*NUM_PAIRS-1:0] o_ch_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NCH = 2*NUM_PAIRS;
    logic [3:0] ctrl_q;
    logic [NCH-1:0] pair_q, oe_exp, ie_exp, ep, cp;
    logic [15:0] fin_q, val_q [NCH];
    logic [4:0] ctl_q [NCH];
    logic wr, run, comp0, mapped;
    // =========================================
    // Decode
    assign wr = i_psel & i_penable & i_pwrite;
    assign run = ctrl_q[0] & ~ctrl_q[3];
    assign comp0 = run & ctrl_q[2] & ~ctrl_q[1] & pair_q[0] & pair_q[1];
    assign mapped = (i_paddr[1:0] == 2'b00) && (i_paddr <= 8'h14
        || (i_paddr >= 8'h20 && i_paddr < 8'h20 + 8'(4*NCH))
        || (i_paddr >= 8'h40 && i_paddr < 8'h40 + 8'(4*NCH)));
    // Shadow of what the assertions need
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_q <= '0;
            pair_q <= '0;
            fin_q <= '0;
            for (int i = 0; i < NCH; i++) begin
                ctl_q[i] <= '0;
                val_q[i] <= '0;
            end
        end else if (wr) begin
            if (i_paddr == `PWM_CTRL_OFF) ctrl_q <= i_pwdata[3:0];
            if (i_paddr == `PWM_FINAL_OFF) fin_q <= i_pwdata[15:0];
            if (i_paddr == `PWM_PAIR_OFF) pair_q <= i_pwdata[NCH-1:0];
            for (int i = 0; i < NCH; i++) begin
                if (i_paddr == `PWM_CHCTL_BASE + 8'(4*i)) ctl_q[i] <= i_pwdata[4:0];
                if (i_paddr == `PWM_CHVAL_BASE + 8'(4*i)) val_q[i] <= i_pwdata[15:0];
            end
        end
    end
    // Per-channel mode with output select 1:0
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            oe_exp[i] = |ctl_q[i][3:2];
            ie_exp[i] = ctl_q[i][4];
            ep[i] = run & ~ctrl_q[1] & ~pair_q[2*(i/2)] & ctl_q[i][1]
                & (ctl_q[i][3:2] == 2'b10);
            cp[i] = run & ctrl_q[1] & ~pair_q[2*(i/2)] & (ctl_q[i][3:2] == 2'b10);
        end
    end
    // =========================================
    // Properties
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_b);
    AST_SLVERR: assert property (i_psel && i_penable |-> o_pslverr == !mapped)
        else $error("slave error wrong");
    AST_OE_ELS: assert property (o_ch_oe == oe_exp)
        else $error("drive enable wrong");
    AST_IRQ_IE: assert property ((o_ch_irq & ~ie_exp) == '0)
        else $error("irq without enable");
    AST_COMP: assert property (comp0 [*3] |-> o_ch_out[1] != o_ch_out[0])
        else $error("odd not inverse");
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        AST_EDGE_ALIGNED_PWM_ZERO: assert property ((ep[g] && val_q[g] == 16'h0000) [*8]
            |-> !o_ch_out[g]) else $error("edge_aligned_pwm zero not low");
        AST_EDGE_ALIGNED_PWM_FULL: assert property ((ep[g] && val_q[g] > fin_q) [*8]
            |-> o_ch_out[g]) else $error("edge_aligned_pwm full not high");
        AST_CENTER_ALIGNED_PWM_ZERO: assert property ((cp[g] && (val_q[g] == 16'h0000
            || val_q[g][15])) [*8] |-> !o_ch_out[g]) else $error("center pwm not low");
        AST_CENTER_ALIGNED_PWM_FULL: assert property ((cp[g] && !val_q[g][15]
            && val_q[g] >= fin_q && fin_q != 16'h0000) [*8] |-> o_ch_out[g])
            else $error("center_aligned_pwm full not high");
    end
    COV_EDGE_ALIGNED_PWM: cover property (|ep);
    COV_CENTER_ALIGNED_PWM: cover property (|cp);
    COV_COMP: cover property (comp0 && o_ch_out[0]);
endmodule : pwm_timer_chk

bind pwm_timer_top pwm_timer_chk #(.NUM_PAIRS(NUM_PAIRS)) pwm_timer_chk_inst (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_ch_out(o_ch_out),
    .o_ch_oe(o_ch_oe), .o_ch_irq(o_ch_irq));

// [testbench/pwm_load_model.sv]
// Load on the channel pins: pull-downs and high-time counters.
// Assumes the bench pulses i_clr to open a measuring window.
module pwm_load_model #(
    parameter int NCH = 4
) (
    // Clock and window control
    input wire logic i_sys_clk,
    input wire logic i_clr,
    // Channel pins
    input wire logic [NCH-1:0] i_ch_out,
    input wire logic [NCH-1:0] i_ch_oe,
    // High-time counts
    output logic [15:0] o_high [NCH]
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [NCH-1:0] pin_lvl;
    // A released pin is pulled low
    assign pin_lvl = i_ch_out & i_ch_oe;
    // Count clock cycles spent high
    always @(posedge i_sys_clk) begin
        for (int i = 0; i < NCH; i++) begin
            o_high[i] <= i_clr ? 16'h0000 : o_high[i] + 16'(pin_lvl[i]);
        end
    end
endmodule : pwm_load_model

// [testbench/timer_channel_pwm_modes_bench.sv]
// Bench: APB set-up, duty, flag and pin checks of the PWM block.
// Assumes a load model that counts high cycles.
`include "pwm_defs.svh"
module timer_channel_pwm_modes_bench import pwm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NCH = 4;
    logic i_sys_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic psel, penable, pwrite, clr, err, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [NCH-1:0] ch_out, ch_oe, ch_irq;
    logic [15:0] high [NCH], hs [NCH], val [NCH];
    logic [4:0] ctl [NCH];
    int hi [NCH];
    int n_mismatch = 0, checks = 0, seed = 78, fin, per, a, b;
    logic [31:0] d;
    // =========================================
    // Design and load
    pwm_timer_top #(.NUM_PAIRS(2)) pwm_timer_top_inst (
        .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_ch_out(ch_out), .o_ch_oe(ch_oe),
        .o_ch_irq(ch_irq));
    pwm_load_model #(.NCH(NCH)) pwm_load_model_inst (.i_sys_clk(i_sys_clk),
        .i_clr(clr), .i_ch_out(ch_out), .i_ch_oe(ch_oe), .o_high(high));
    // Clock
    initial forever #25 i_sys_clk = ~i_sys_clk;
    // =========================================
    // Helpers
    function automatic int rnd(input int lo, input int hi_v);
        return lo + int'($unsigned($random(seed)) % (hi_v - lo + 1));
    endfunction : rnd
    // High cycles in three periods; inverted select counts low time
    function automatic int duty(input int h, input int p, input logic inv);
        return (inv ? p - h : h) * 3;
    endfunction : duty
    task automatic cmp(input string what, input int idx, input logic [31:0] exp,
            input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s[%0d] expected %h seen %h", what, idx, exp, got);
        end
    endtask : cmp
    // One APB transfer; only the watchdog ends a wait
    task automatic apb(input logic [7:0] adr, input logic w, input logic [31:0] wd);
        @(posedge i_sys_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, adr, wd};
        @(posedge i_sys_clk);
        penable <= 1'b1;
        do @(posedge i_sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    // Stop, program, run, clear flags, measure three periods, read flags
    task automatic run_case(input logic [3:0] c, input logic [3:0] pr);
        apb(`PWM_CTRL_OFF, 1'b1, 32'h0);
        apb(`PWM_FINAL_OFF, 1'b1, 32'(fin));
        apb(`PWM_PAIR_OFF, 1'b1, 32'(pr));
        for (int i = 0; i < NCH; i++) begin
            apb(`PWM_CHCTL_BASE + 8'(4*i), 1'b1, 32'(ctl[i]));
            apb(`PWM_CHVAL_BASE + 8'(4*i), 1'b1, 32'(val[i]));
        end
        apb(`PWM_CTRL_OFF, 1'b1, 32'(c));
        repeat (2*per) @(posedge i_sys_clk);
        apb(`PWM_FLAG_OFF, 1'b1, 32'hf);
        @(posedge i_sys_clk);
        clr <= 1'b1;
        @(posedge i_sys_clk);
        clr <= 1'b0;
        repeat (3*per) @(posedge i_sys_clk);
        #1;
        hs = high;
        apb(`PWM_FLAG_OFF, 1'b0, 32'h0);
    endtask : run_case
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    // Watchdog, far past the run's length
    initial begin
        #(20000*50);
        n_mismatch++;
        tally_and_finish();
    end
    // =========================================
    // Main sequence
    initial begin
        {psel, penable, pwrite, clr, paddr, pwdata} = '0;
        repeat (5) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        apb(`PWM_CTRL_OFF, 1'b0, 32'h0);
        cmp("ctrl_reset", 0, 32'h0, rd);
        for (int i = 0; i < NCH; i++) begin
            d = $random(seed);
            apb(`PWM_CHVAL_BASE + 8'(4*i), 1'b1, d);
            apb(`PWM_CHVAL_BASE + 8'(4*i), 1'b0, 32'h0);
            cmp("chval", i, {16'h0000, d[15:0]}, rd);
        end
        apb(8'h18, 1'b1, 32'hffffffff);
        cmp("unmapped_err", 0, 32'h1, 32'(err));
        apb(8'h18, 1'b0, 32'h0);
        cmp("unmapped_rd", 0, 32'h0, rd);
        // Edge-aligned: plain, inverted, zero and above-final values
        fin = rnd(6, 13);
        per = fin + 1;
        a = rnd(1, fin - 1);
        b = rnd(1, fin - 1);
        ctl = '{5'h1a, 5'h06, 5'h0a, 5'h0a};
        val = '{16'(a), 16'(b), 16'h0000, 16'(fin + 1)};
        hi = '{duty(a, per, 0), duty(b, per, 1), 0, duty(per, per, 0)};
        run_case(4'h1, 4'h0);
        for (int i = 0; i < NCH; i++) cmp("edge_aligned_pwm_high", i, hi[i], 32'(hs[i]));
        cmp("edge_aligned_pwm_flags", 0, 32'h3, rd);
        cmp("edge_aligned_pwm_irq", 0, 32'h1, 32'(ch_irq));
        // Center-aligned: negative 0%, at final 100%
        per = 2 * fin;
        val = '{16'(a), 16'(b), 16'h8000, 16'(fin)};
        hi = '{duty(2*a, per, 0), duty(2*b, per, 1), 0, duty(per, per, 0)};
        run_case(4'h3, 4'h0);
        for (int i = 0; i < NCH; i++) cmp("center_aligned_pwm_high", i, hi[i], 32'(hs[i]));
        cmp("center_aligned_pwm_flags", 0, 32'h3, rd);
        cmp("center_aligned_pwm_irq", 0, 32'h1, 32'(ch_irq));
        // Combine: pair 0 complementary, pair 1 inverted and copied
        per = fin + 1;
        a = rnd(1, fin - 3);
        b = rnd(a + 1, fin - 1);
        ctl = '{5'h1a, 5'h0a, 5'h06, 5'h0a};
        val = '{16'(a), 16'(b), 16'(a + 1), 16'(fin - 1)};
        hi = '{duty(b - a, per, 0), duty(b - a, per, 1), duty(fin - a - 2, per, 1),
            duty(fin - a - 2, per, 1)};
        run_case(4'h5, 4'h7);
        for (int i = 0; i < NCH; i++) cmp("comb_high", i, hi[i], 32'(hs[i]));
        cmp("comb_flags", 0, 32'hf, rd);
        cmp("comb_irq", 0, 32'h1, 32'(ch_irq));
        // Released pins still flag
        ctl = '{5'h12, 5'h01, 5'h00, 5'h00};
        val = '{16'(a), 16'(b), 16'(a), 16'(b)};
        for (int c = 0; c < 2; c++) begin
            per = c ? 2 * fin : fin + 1;
            run_case(c ? 4'h3 : 4'h1, 4'h0);
            for (int i = 0; i < NCH; i++) cmp("free_high", i, 32'h0, 32'(hs[i]));
            cmp("free_oe", c, 32'h0, 32'(ch_oe));
            cmp("free_flags", c, c ? 32'hf : 32'h3, rd);
        end
        tally_and_finish();
    end
endmodule : timer_channel_pwm_modes_bench
